// ---- design/dtm_monitor.sv ----
// What this block does
// - Both filtered channels low: inhibit drive and turn safe status on.
// - Both filtered channels high: release inhibit, status off.
// - Exactly one channel high: keep inhibit, status off.
// - No fault while channels disagree for 1.6 s or less.
// - Fault always declared once disagreement lasts beyond 3.0 s.
// - On timeout enter locked state: inhibit on, status off, channel inputs ignored.
// - Locked state leaves only by full power cycle, nothing else.
// - Low test pulses narrower than 2 ms never invoke the inhibit.
// - A channel going low acts after staying low about 6 ms.
// - Trip raised at start attempt or while running if inhibited or faulted.
// - Log trip entry at start attempt when inhibited or inhibit while running.
// - No trip entry when inhibit becomes active while not running.
// - Mismatch detection time nominally 2.3 s, between minimum and maximum.
`timescale 1ns/100ps
`default_nettype none
module dtm_monitor
	import dtm_pkg::*;
#(
	parameter int unsigned REACT_CYCLES = REACT_CYC,
	parameter int unsigned MISMATCH_CYCLES = MISMATCH_CYC
)
(
	// Clock and power-on reset
	input wire logic clock,
	input wire logic resetn,
	// Safety channel pins
	input wire logic safety_channel_a_input,
	input wire logic safety_channel_b_input,
	// Drive control side
	input wire logic start_request,
	input wire logic drive_running,
	// Results
	output logic drive_inhibit,
	output logic safe_state_status_positive,
	output logic safe_state_status_negative,
	output logic lockout_fault,
	output logic torque_off_trip,
	output logic trip_log_pulse
);

	logic [1:0] sync1_r;
	logic [1:0] sync2_r;
	dtm_chan_s filt_r, filt_nxt;
	dtm_filt_t low_cnt_r [2];
	dtm_filt_t low_cnt_nxt [2];
	dtm_disc_t disc_r, disc_nxt;
	dtm_state_e state_r, state_nxt;
	logic inhibit_r, inhibit_nxt;
	logic stat_r, stat_nxt;
	logic trip_r, trip_nxt;
	logic log_r, log_nxt;
	logic fault_r, fault_nxt;
	logic inhibit_was_r;

	// True while the two filtered channels hold opposite levels.
	function automatic logic chans_disagree(input dtm_chan_s c);
		return c.chan_a != c.chan_b;
	endfunction

	// Pins come from outside the clock domain.
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
		end
		else
		begin
			sync1_r <= {safety_channel_a_input, safety_channel_b_input};
			sync2_r <= sync1_r;
		end
	end

	// High is taken at once; low only after a full reaction time.
	// Rising straight through keeps the restart path fast, while the long low
	// qualification is what swallows test pulses.
	always_comb
	begin
		filt_nxt = filt_r;
		low_cnt_nxt = low_cnt_r;
		for (int i = 0; i < 2; i++)
		begin
			if (sync2_r[1-i])
				low_cnt_nxt[i] = '0;
			else if (low_cnt_r[i] < FILT_W'(REACT_CYCLES))
				low_cnt_nxt[i] = low_cnt_r[i] + FILT_W'(1);
		end
		filt_nxt.chan_a = sync2_r[1] ? 1'b1 : (low_cnt_nxt[0] >= FILT_W'(REACT_CYCLES) ? 1'b0 : filt_r.chan_a);
		filt_nxt.chan_b = sync2_r[0] ? 1'b1 : (low_cnt_nxt[1] >= FILT_W'(REACT_CYCLES) ? 1'b0 : filt_r.chan_b);
	end

	// Mismatch timer and state.
	always_comb
	begin
		disc_nxt = '0;
		state_nxt = state_r;
		unique case (state_r)
			DTM_LOCKED:
				state_nxt = DTM_LOCKED;
			// Every code of the two-bit state is legal, so there is no default arm.
			DTM_SAFE, DTM_RUN_OK, DTM_MISMATCH:
			begin
				if (chans_disagree(filt_r))
				begin
					disc_nxt = disc_r + DISC_W'(1);
					if (disc_nxt >= DISC_W'(MISMATCH_CYCLES))
						state_nxt = DTM_LOCKED;
					else
						state_nxt = DTM_MISMATCH;
				end
				else if (filt_r.chan_a)
					state_nxt = DTM_RUN_OK;
				else
					state_nxt = DTM_SAFE;
			end
		endcase
		inhibit_nxt = (state_nxt != DTM_RUN_OK);
		stat_nxt = (state_nxt == DTM_SAFE);
		fault_nxt = (state_nxt == DTM_LOCKED);
		trip_nxt = inhibit_r && (start_request || drive_running);
		log_nxt = inhibit_r && ((start_request && !drive_running) || (drive_running && !inhibit_was_r));
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			filt_r <= '0;
			low_cnt_r[0] <= '0;
			low_cnt_r[1] <= '0;
			disc_r <= '0;
			state_r <= DTM_SAFE;
			inhibit_r <= 1'b1;
			stat_r <= 1'b1;
			trip_r <= 1'b0;
			log_r <= 1'b0;
			fault_r <= 1'b0;
			inhibit_was_r <= 1'b1;
		end
		else
		begin
			filt_r <= filt_nxt;
			low_cnt_r <= low_cnt_nxt;
			disc_r <= disc_nxt;
			state_r <= state_nxt;
			inhibit_r <= inhibit_nxt;
			stat_r <= stat_nxt;
			trip_r <= trip_nxt;
			log_r <= log_nxt;
			fault_r <= fault_nxt;
			inhibit_was_r <= inhibit_r;
		end
	end

	assign drive_inhibit = inhibit_r;
	assign safe_state_status_positive = stat_r;
	assign safe_state_status_negative = stat_r;
	assign lockout_fault = fault_r;
	assign torque_off_trip = trip_r;
	assign trip_log_pulse = log_r;

	chk_lock_holds: assert property (@(posedge clock) disable iff (!resetn)
		fault_r |=> fault_r && inhibit_r && !stat_r) else $error("lockout released");
	chk_lock_inhibits: assert property (@(posedge clock) disable iff (!resetn)
		state_r == DTM_LOCKED |-> ##1 (inhibit_r && !stat_r)) else $error("locked but not inhibited");
	chk_mismatch_fault: assert property (@(posedge clock) disable iff (!resetn)
		(disc_r == DISC_W'(MISMATCH_CYCLES - 1) && chans_disagree(filt_r)) |=> state_r == DTM_LOCKED)
		else $error("mismatch timeout missed");
	chk_no_early_fault: assert property (@(posedge clock) disable iff (!resetn)
		$rose(fault_r) |-> $past(disc_r) >= DISC_W'(MISMATCH_CYCLES - 1)) else $error("fault too early");
	chk_both_low: assert property (@(posedge clock) disable iff (!resetn)
		(!filt_r.chan_a && !filt_r.chan_b && state_r != DTM_LOCKED) |=> (inhibit_r && stat_r))
		else $error("safe state not shown");
	chk_both_high: assert property (@(posedge clock) disable iff (!resetn)
		(filt_r.chan_a && filt_r.chan_b && state_r != DTM_LOCKED) |=> (!inhibit_r && !stat_r))
		else $error("inhibit not released");
	chk_one_high: assert property (@(posedge clock) disable iff (!resetn)
		chans_disagree(filt_r) |=> (inhibit_r && !stat_r)) else $error("single channel not inhibited");
	chk_short_pulse: assert property (@(posedge clock) disable iff (!resetn)
		($fell(sync2_r[1]) && filt_r.chan_a) ##1 (!sync2_r[1]) [*3] ##1 sync2_r[1]
		|-> filt_r.chan_a ##1 filt_r.chan_a)
		else $error("short pulse reached filter");
	chk_trip_flag: assert property (@(posedge clock) disable iff (!resetn)
		(inhibit_r && drive_running) |=> torque_off_trip) else $error("trip not raised");
	chk_log_idle: assert property (@(posedge clock) disable iff (!resetn)
		(!drive_running && !start_request) |=> !trip_log_pulse) else $error("log while idle");

	// A four-cycle low pulse is far below the immunity width at any usable clock rate.
	chk_short_pulse_b: assert property (@(posedge clock) disable iff (!resetn)
		($fell(sync2_r[0]) && filt_r.chan_b) ##1 (!sync2_r[0]) [*3] ##1 sync2_r[0]
		|-> filt_r.chan_b ##1 filt_r.chan_b)
		else $error("short pulse on B reached filter");
	chk_react_a: assert property (@(posedge clock) disable iff (!resetn)
		$fell(filt_r.chan_a) |-> (!$past(sync2_r[1]) && !$past(sync2_r[1], 2)))
		else $error("channel A dropped too soon");
	chk_react_b: assert property (@(posedge clock) disable iff (!resetn)
		$fell(filt_r.chan_b) |-> (!$past(sync2_r[0]) && !$past(sync2_r[0], 2)))
		else $error("channel B dropped too soon");
	chk_fast_release: assert property (@(posedge clock) disable iff (!resetn)
		(&sync2_r) |=> (filt_r.chan_a && filt_r.chan_b))
		else $error("high channels not passed");
	chk_log_start: assert property (@(posedge clock) disable iff (!resetn)
		(inhibit_r && start_request && !drive_running) |=> trip_log_pulse)
		else $error("start attempt not logged");
	chk_log_rise: assert property (@(posedge clock) disable iff (!resetn)
		($rose(inhibit_r) && drive_running) |=> trip_log_pulse)
		else $error("inhibit while running not logged");
	chk_trip_start: assert property (@(posedge clock) disable iff (!resetn)
		(inhibit_r && start_request) |=> torque_off_trip)
		else $error("start attempt not tripped");
	chk_trip_clear: assert property (@(posedge clock) disable iff (!resetn)
		!inhibit_r |=> !torque_off_trip)
		else $error("trip without inhibit");
	// This one watches the reset itself, so it cannot share the reset disable.
	chk_power_on: assert property (@(posedge clock)
		(!resetn ##1 !resetn) |-> (inhibit_r && stat_r && !fault_r && state_r == DTM_SAFE))
		else $error("power-on state wrong");

endmodule
`default_nettype wire

// ---- design/dtm_pkg.sv ----
package dtm_pkg;

	// Sampling clock rate.
	localparam int unsigned CLOCK_HZ = 10_000_000;
	localparam int unsigned CLOCK_PERIOD_NS = 100;

	// Timing figures in their own units.
	localparam int unsigned PULSE_IMMUNE_MS = 2;
	localparam int unsigned REACT_TYP_MS = 6;
	localparam int unsigned MISMATCH_MIN_MS = 1600;
	localparam int unsigned MISMATCH_TYP_MS = 2300;
	localparam int unsigned MISMATCH_MAX_MS = 3000;

	// Cycle counts derived from the rate.
	localparam int unsigned CYC_PER_MS = CLOCK_HZ / 1000;
	localparam int unsigned REACT_CYC = REACT_TYP_MS * CYC_PER_MS;
	localparam int unsigned IMMUNE_CYC = PULSE_IMMUNE_MS * CYC_PER_MS;
	localparam int unsigned MISMATCH_CYC = MISMATCH_TYP_MS * CYC_PER_MS;
	localparam int unsigned MISMATCH_MIN_CYC = MISMATCH_MIN_MS * CYC_PER_MS;
	localparam int unsigned MISMATCH_MAX_CYC = MISMATCH_MAX_MS * CYC_PER_MS;

	localparam int FILT_W = 17;
	localparam int DISC_W = 26;

	typedef logic [FILT_W-1:0] dtm_filt_t;
	typedef logic [DISC_W-1:0] dtm_disc_t;

	typedef enum logic [1:0] {
		DTM_SAFE = 2'b00,
		DTM_RUN_OK = 2'b01,
		DTM_MISMATCH = 2'b10,
		DTM_LOCKED = 2'b11
	} dtm_state_e;

	// Filtered view of the two channels.
	typedef struct packed {
		logic chan_a;
		logic chan_b;
	} dtm_chan_s;

endpackage

// ---- testbench/dtm_relay_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dtm_relay_model
(
	// Requested contact state, A then B
	input wire logic [1:0] want,
	// Contact outputs
	output logic chan_a,
	output logic chan_b
);
	// Both contacts follow one request, so no skew is added between them.
	assign chan_a = want[1];
	assign chan_b = want[0];
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int RC = 8;
	localparam int MC = 40;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] want = 2'h0;
	logic start_request = 1'b0;
	logic drive_running = 1'b0;
	wire logic ch_a, ch_b, inh, sp, sn, lock, trip, logp;
	wire logic [3:0] outs = {inh, sp, sn, lock};
	int miscompares = 0;
	int n_compared = 0;
	int n_log = 0;
	int n0;
	dtm_relay_model i_relay (.want(want), .chan_a(ch_a), .chan_b(ch_b));
	dtm_monitor #(.REACT_CYCLES(RC), .MISMATCH_CYCLES(MC)) i_dut (.clock(clock), .resetn(resetn),
		.safety_channel_a_input(ch_a), .safety_channel_b_input(ch_b), .start_request(start_request),
		.drive_running(drive_running), .drive_inhibit(inh), .safe_state_status_positive(sp),
		.safe_state_status_negative(sn), .lockout_fault(lock), .torque_off_trip(trip), .trip_log_pulse(logp));
	initial forever #50 clock = ~clock;
	// Log pulses are counted on the sampling edge so that none slips between checks.
	always @(posedge clock) if (logp === 1'b1) n_log++;
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic drive(input logic [1:0] w);
		@(posedge clock);
		want <= w;
	endtask
	task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_reset();
		cyc(2);
		check("reset outs", outs, 4'hE);
		@(posedge clock);
		resetn <= 1'b1;
		cyc(2);
		check("after reset", outs, 4'hE);
		$display("t_reset done");
	endtask
	task automatic t_filter();
		drive(2'h3);
		cyc(6);
		check("both high", outs, 4'h0);
		drive(2'h1);
		cyc(3);
		drive(2'h3);
		cyc(RC + 4);
		check("short pulse", outs, 4'h0);
		drive(2'h2);
		cyc(3);
		drive(2'h3);
		cyc(RC + 4);
		check("short pulse b", outs, 4'h0);
		drive(2'h1);
		cyc(RC - 2);
		check("low not yet seen", outs, 4'h0);
		cyc(8);
		check("one high", outs, 4'h8);
		drive(2'h3);
		cyc(6);
		check("short mismatch", outs, 4'h0);
		$display("t_filter done");
	endtask
	task automatic t_trip();
		n0 = n_log;
		@(posedge clock);
		drive_running <= 1'b1;
		drive(2'h0);
		cyc(RC + 6);
		check("both low", outs, 4'hE);
		check("trip running", {3'h0, trip}, 4'h1);
		check("log running", 4'(n_log - n0), 4'h1);
		@(posedge clock);
		drive_running <= 1'b0;
		cyc(2);
		n0 = n_log;
		@(posedge clock);
		start_request <= 1'b1;
		@(posedge clock);
		start_request <= 1'b0;
		#1;
		check("trip start", {3'h0, trip}, 4'h1);
		cyc(2);
		check("log start", 4'(n_log - n0), 4'h1);
		check("trip cleared", {3'h0, trip}, 4'h0);
		$display("t_trip done");
	endtask
	task automatic t_lock();
		drive(2'h3);
		cyc(6);
		n0 = n_log;
		drive(2'h2);
		cyc(RC + MC + 12);
		check("locked", outs, 4'h9);
		check("log idle", 4'(n_log - n0), 4'h0);
		drive(2'h3);
		cyc(10);
		check("locked high", outs, 4'h9);
		drive(2'h0);
		cyc(RC + 6);
		check("locked low", outs, 4'h9);
		$display("t_lock done");
	endtask
	task automatic t_power();
		@(posedge clock);
		resetn <= 1'b0;
		cyc(3);
		check("power off", outs, 4'hE);
		@(posedge clock);
		resetn <= 1'b1;
		want <= 2'h3;
		cyc(8);
		check("power on run", outs, 4'h0);
		$display("t_power done");
	endtask
	initial
	begin
		t_reset();
		t_filter();
		t_trip();
		t_lock();
		t_power();
		results();
	end
endmodule
`default_nettype wire
